// ---- inc/csic_flag_if.sv ----
// csic_flag_if: carrier between control logic and one socket's flag logic
`timescale 1ns/10ps
interface csic_flag_if;
   logic [3:0] src_enable;
   logic       card_io;
   logic       ring_en;
   logic       read_clear;
   logic [3:0] write_clear;
   logic [3:0] flags;
   logic       pending;

   modport ctrl (
      output src_enable,
      output card_io,
      output ring_en,
      output read_clear,
      output write_clear,
      input  flags,
      input  pending
   );

   modport flag (
      input  src_enable,
      input  card_io,
      input  ring_en,
      input  read_clear,
      input  write_clear,
      output flags,
      output pending
   );
endinterface

// ---- inc/csic_pkg.sv ----
// csic_pkg: shared constants of the card socket interrupt control block
package csic_pkg;
   localparam int         NUM_SOCKETS    = 2;
   localparam int         ADDR_W         = 7;
   localparam int         DATA_W         = 8;
   localparam int         SEL_W          = 4;
   localparam int         FLAG_W         = 4;
   localparam int         IRQ_LINES      = 16;
   localparam int         SYNC_STAGES    = 2;

   // register offsets within the socket window
   localparam logic [6:0] OFS_CTRL       = 7'h03;
   localparam logic [6:0] OFS_STAT       = 7'h04;
   localparam logic [6:0] SOCKET_STRIDE  = 7'h40;

   // reset values
   localparam logic [7:0] CTRL_RESET     = 8'h00;
   localparam logic [3:0] STAT_RESET     = 4'h0;
   localparam logic [7:0] RDATA_RESET    = 8'h00;
   localparam logic [7:0] UNMAPPED_READ  = 8'h00;

   // control register fields
   localparam int         CTRL_RING_BIT  = 7;
   localparam int         CTRL_RESET_BIT = 6;
   localparam int         CTRL_KIND_BIT  = 5;
   localparam int         CTRL_ROUTE_BIT = 4;
   localparam int         CTRL_SEL_LSB   = 0;

   // status-change flag positions
   localparam int         FLAG_DETECT    = 3;
   localparam int         FLAG_READY     = 2;
   localparam int         FLAG_BATLOW    = 1;
   localparam int         FLAG_BATTERY_DEAD_FLAG   = 0;
   localparam logic [3:0] FLAG_ALL       = 4'hF;
   localparam logic [3:0] FLAG_NONE      = 4'h0;

   // interrupt select codes
   localparam logic [3:0] SEL_NONE       = 4'h0;
   localparam logic [3:0] SEL_SMI        = 4'h2;

   // battery detect encodings {bvd2, bvd1}
   localparam logic [1:0] BVD_LOW        = 2'h2;
endpackage

// ---- rtl/csic_flags.sv ----
// csic_flags: status-change flag bits of one socket
`timescale 1ns/10ps
module csic_flags (
   input  logic             clk_sys,
   input  logic             reset_n,
   input  logic             ce,
   input  logic [1:0]       card_detect_n,
   input  logic             card_ready,
   input  logic [1:0]       battery_detect,
   csic_flag_if.flag        fi
);
   logic [1:0] prev_cd_q;
   logic [1:0] prev_cd_d;
   logic       prev_ready_q;
   logic       prev_ready_d;
   logic       prev_low_q;
   logic       prev_low_d;
   logic       prev_dead_q;
   logic       prev_dead_d;
   logic       armed_q;
   logic       armed_d;
   logic [1:0] arm_cnt_q;
   logic [1:0] arm_cnt_d;
   logic [3:0] flags_q;
   logic [3:0] flags_d;
   logic       pending_q;
   logic       pending_d;
   logic [3:0] evt;
   logic [3:0] clr;
   logic [3:0] io_zero;
   logic       low_now;
   logic       dead_now;

   always_comb begin
      low_now   = (battery_detect == csic_pkg::BVD_LOW);
      dead_now  = ~battery_detect[0];
      evt       = csic_pkg::FLAG_NONE;
      evt[csic_pkg::FLAG_DETECT] = armed_q & (card_detect_n != prev_cd_q);
      evt[csic_pkg::FLAG_READY]  = armed_q & card_ready & ~prev_ready_q;
      evt[csic_pkg::FLAG_BATLOW] = armed_q & low_now & ~prev_low_q;
      if (fi.ring_en || fi.card_io) begin
         evt[csic_pkg::FLAG_BATTERY_DEAD_FLAG] = armed_q & ~battery_detect[0];
      end else begin
         evt[csic_pkg::FLAG_BATTERY_DEAD_FLAG] = armed_q & dead_now & ~prev_dead_q;
      end
      io_zero   = csic_pkg::FLAG_NONE;
      io_zero[csic_pkg::FLAG_READY]  = fi.card_io;
      io_zero[csic_pkg::FLAG_BATLOW] = fi.card_io;
      clr       = fi.read_clear ? csic_pkg::FLAG_ALL : fi.write_clear;
      // a new event wins over a clear in the same cycle
      flags_d   = ((flags_q & ~clr) | evt) & fi.src_enable & ~io_zero;
      pending_d = |flags_d;
      prev_cd_d    = card_detect_n;
      prev_ready_d = card_ready;
      prev_low_d   = low_now;
      prev_dead_d  = dead_now;
      // detectors wait until the synchroniser holds real pin levels
      armed_d      = armed_q | (arm_cnt_q == 2'(csic_pkg::SYNC_STAGES));
      arm_cnt_d    = armed_q ? arm_cnt_q : 2'(arm_cnt_q + 2'h1);
      if (!ce) begin
         arm_cnt_d    = arm_cnt_q;
         flags_d      = flags_q;
         pending_d    = pending_q;
         prev_cd_d    = prev_cd_q;
         prev_ready_d = prev_ready_q;
         prev_low_d   = prev_low_q;
         prev_dead_d  = prev_dead_q;
         armed_d      = armed_q;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prev_cd_q    <= 2'h0;
         prev_ready_q <= 1'b0;
         prev_low_q   <= 1'b0;
         prev_dead_q  <= 1'b0;
         armed_q      <= 1'b0;
         arm_cnt_q    <= 2'h0;
         flags_q      <= csic_pkg::STAT_RESET;
         pending_q    <= 1'b0;
      end else begin
         prev_cd_q    <= prev_cd_d;
         prev_ready_q <= prev_ready_d;
         prev_low_q   <= prev_low_d;
         prev_dead_q  <= prev_dead_d;
         armed_q      <= armed_d;
         arm_cnt_q    <= arm_cnt_d;
         flags_q      <= flags_d;
         pending_q    <= pending_d;
      end
   end

   assign fi.flags   = flags_q;
   assign fi.pending = pending_q;
endmodule

// ---- rtl/csic_sync.sv ----
// csic_sync: two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module csic_sync #(
   parameter int WIDTH = 1
) (
   input  logic             clk_sys,
   input  logic             reset_n,
   input  logic             ce,
   input  logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   always_comb begin
      meta_d = ce ? async_in : meta_q;
      sync_d = ce ? meta_q : sync_q;
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign sync_out = sync_q;
endmodule

// ---- rtl/csic_top.sv ----
// csic_top: two-socket control and status-change interrupt logic
`timescale 1ns/10ps
module csic_top #(
   parameter int NUM_SOCKETS = csic_pkg::NUM_SOCKETS,
   parameter int IRQ_LINES   = csic_pkg::IRQ_LINES
) (
   input  logic                        clk_sys,
   input  logic                        reset_n,
   input  logic                        ce,
   input  logic [6:0]                  reg_addr,
   input  logic                        reg_wr,
   input  logic                        reg_rd,
   input  logic [7:0]                  reg_wdata,
   output logic [7:0]                  reg_rdata,
   output logic                        reg_rvalid,
   input  logic [NUM_SOCKETS-1:0]      flag_clear_write_mode,
   input  logic [NUM_SOCKETS-1:0][3:0] status_change_src_enable,
   input  logic [NUM_SOCKETS-1:0][3:0] status_change_irq_select,
   input  logic [NUM_SOCKETS-1:0][1:0] card_detect_n,
   input  logic [NUM_SOCKETS-1:0]      card_ready,
   input  logic [NUM_SOCKETS-1:0]      battery_detect1_ring_pin,
   input  logic [NUM_SOCKETS-1:0]      battery_detect2,
   output logic [NUM_SOCKETS-1:0]      ring_indicate_enable,
   output logic [NUM_SOCKETS-1:0]      card_reset,
   output logic [NUM_SOCKETS-1:0]      socket_card_kind,
   output logic [NUM_SOCKETS-1:0]      pci_irq,
   output logic [IRQ_LINES-1:0]        irq_line,
   output logic                        smi_req
);
   localparam int PIN_W = 5;

   logic [NUM_SOCKETS-1:0][7:0]       ctrl_q;
   logic [NUM_SOCKETS-1:0][7:0]       ctrl_d;
   logic [NUM_SOCKETS-1:0]            card_reset_q;
   logic [NUM_SOCKETS-1:0]            card_reset_d;
   logic [NUM_SOCKETS-1:0]            pci_irq_q;
   logic [NUM_SOCKETS-1:0]            pci_irq_d;
   logic [IRQ_LINES-1:0]              irq_line_q;
   logic [IRQ_LINES-1:0]              irq_line_d;
   logic                              smi_q;
   logic                              smi_d;
   logic [7:0]                        rdata_q;
   logic [7:0]                        rdata_d;
   logic                              rvalid_q;
   logic                              rvalid_d;

   logic [NUM_SOCKETS-1:0]            hit_ctrl;
   logic [NUM_SOCKETS-1:0]            hit_stat;
   logic [NUM_SOCKETS-1:0]            read_clear;
   logic [NUM_SOCKETS-1:0][3:0]       write_clear;
   logic [NUM_SOCKETS-1:0][3:0]       flags;
   logic [NUM_SOCKETS-1:0]            pending;
   logic [NUM_SOCKETS-1:0][PIN_W-1:0] pin_raw;
   logic [NUM_SOCKETS-1:0][PIN_W-1:0] pin_sync;

   // pin synchronisers and flag logic, one per socket
   for (genvar s = 0; s < NUM_SOCKETS; s++) begin : g_sock
      csic_flag_if fi ();

      assign pin_raw[s] = {card_detect_n[s], card_ready[s],
                           battery_detect2[s], battery_detect1_ring_pin[s]};

      csic_sync #(
         .WIDTH    (PIN_W)
      ) u_sync (
         .clk_sys  (clk_sys),
         .reset_n  (reset_n),
         .ce       (ce),
         .async_in (pin_raw[s]),
         .sync_out (pin_sync[s])
      );

      assign fi.src_enable  = status_change_src_enable[s];
      assign fi.card_io     = ctrl_q[s][csic_pkg::CTRL_KIND_BIT];
      assign fi.ring_en     = ctrl_q[s][csic_pkg::CTRL_RING_BIT];
      assign fi.read_clear  = read_clear[s];
      assign fi.write_clear = write_clear[s];
      assign flags[s]       = fi.flags;
      assign pending[s]     = fi.pending;

      csic_flags u_flags (
         .clk_sys        (clk_sys),
         .reset_n        (reset_n),
         .ce             (ce),
         .card_detect_n  (pin_sync[s][4:3]),
         .card_ready     (pin_sync[s][2]),
         .battery_detect (pin_sync[s][1:0]),
         .fi             (fi.flag)
      );
   end

   // address decode per socket window
   always_comb begin
      for (int s = 0; s < NUM_SOCKETS; s++) begin
         hit_ctrl[s] = (reg_addr == 7'(csic_pkg::OFS_CTRL + s * csic_pkg::SOCKET_STRIDE));
         hit_stat[s] = (reg_addr == 7'(csic_pkg::OFS_STAT + s * csic_pkg::SOCKET_STRIDE));
         read_clear[s]  = ce & reg_rd & hit_stat[s] & ~flag_clear_write_mode[s];
         write_clear[s] = (ce & reg_wr & hit_stat[s] & flag_clear_write_mode[s]) ?
                          reg_wdata[3:0] : csic_pkg::FLAG_NONE;
      end
   end

   // register file and read port
   always_comb begin
      ctrl_d   = ctrl_q;
      rdata_d  = rdata_q;
      rvalid_d = 1'b0;
      if (reg_rd) begin
         rdata_d  = csic_pkg::UNMAPPED_READ;
         rvalid_d = 1'b1;
      end
      for (int s = 0; s < NUM_SOCKETS; s++) begin
         if (reg_wr && hit_ctrl[s]) begin
            ctrl_d[s] = reg_wdata;
         end
         if (reg_rd && hit_ctrl[s]) begin
            rdata_d = ctrl_q[s];
         end
         if (reg_rd && hit_stat[s]) begin
            rdata_d = {4'h0, flags[s]};
         end
      end
      if (!ce) begin
         ctrl_d   = ctrl_q;
         rdata_d  = rdata_q;
         rvalid_d = rvalid_q;
      end
   end

   // pin-facing control and interrupt routing
   always_comb begin
      logic [3:0] fsel;
      logic [3:0] csel;
      logic       to_pci;
      logic       func_act;
      fsel       = csic_pkg::SEL_NONE;
      csel       = csic_pkg::SEL_NONE;
      to_pci     = 1'b0;
      func_act   = 1'b0;
      irq_line_d = '0;
      smi_d      = 1'b0;
      for (int s = 0; s < NUM_SOCKETS; s++) begin
         card_reset_d[s] = ~ctrl_q[s][csic_pkg::CTRL_RESET_BIT];
         fsel     = ctrl_q[s][csic_pkg::CTRL_SEL_LSB +: csic_pkg::SEL_W];
         csel     = status_change_irq_select[s];
         to_pci   = ctrl_q[s][csic_pkg::CTRL_ROUTE_BIT] | (fsel == csic_pkg::SEL_NONE);
         pci_irq_d[s] = pending[s] & to_pci;
         // an I/O card requests its functional interrupt by pulling ready low
         func_act = ctrl_q[s][csic_pkg::CTRL_KIND_BIT] & ~pin_sync[s][2];
         if (func_act && fsel == csic_pkg::SEL_SMI) begin
            smi_d = 1'b1;
         end else if (func_act && fsel != csic_pkg::SEL_NONE) begin
            irq_line_d[fsel] = 1'b1;
         end
         if (pending[s] && !to_pci) begin
            if (csel == csic_pkg::SEL_SMI) begin
               smi_d = 1'b1;
            end else if (csel != csic_pkg::SEL_NONE) begin
               irq_line_d[csel] = 1'b1;
            end
         end
      end
      if (!ce) begin
         card_reset_d = card_reset_q;
         pci_irq_d    = pci_irq_q;
         irq_line_d   = irq_line_q;
         smi_d        = smi_q;
      end
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         for (int s = 0; s < NUM_SOCKETS; s++) begin
            ctrl_q[s] <= csic_pkg::CTRL_RESET;
         end
         card_reset_q <= '1;
         pci_irq_q    <= '0;
         irq_line_q   <= '0;
         smi_q        <= 1'b0;
         rdata_q      <= csic_pkg::RDATA_RESET;
         rvalid_q     <= 1'b0;
      end else begin
         ctrl_q       <= ctrl_d;
         card_reset_q <= card_reset_d;
         pci_irq_q    <= pci_irq_d;
         irq_line_q   <= irq_line_d;
         smi_q        <= smi_d;
         rdata_q      <= rdata_d;
         rvalid_q     <= rvalid_d;
      end
   end

   always_comb begin
      for (int s = 0; s < NUM_SOCKETS; s++) begin
         ring_indicate_enable[s] = ctrl_q[s][csic_pkg::CTRL_RING_BIT];
         socket_card_kind[s]     = ctrl_q[s][csic_pkg::CTRL_KIND_BIT];
      end
   end

   assign card_reset = card_reset_q;
   assign pci_irq    = pci_irq_q;
   assign irq_line   = irq_line_q;
   assign smi_req    = smi_q;
   assign reg_rdata  = rdata_q;
   assign reg_rvalid = rvalid_q;
endmodule

// ---- verification/csic_card.sv ----
// csic_card: behavioural card pins for both sockets
`timescale 1ns/10ps
module csic_card (
   output logic [1:0][1:0] card_detect_n,
   output logic [1:0]      card_ready,
   output logic [1:0]      battery_detect1_ring_pin,
   output logic [1:0]      battery_detect2
);
   initial begin
      card_detect_n = '0;
      card_ready = '1;
      battery_detect1_ring_pin = '1;
      battery_detect2 = '1;
   end
   // pins move at a moment unrelated to the host clock
   task automatic pins(input int s, input logic [1:0] cd, input logic r, b1, b2);
      #($urandom % 7);
      card_detect_n[s] = cd;
      card_ready[s] = r;
      battery_detect1_ring_pin[s] = b1;
      battery_detect2[s] = b2;
   endtask
endmodule

// ---- verification/csic_sva.sv ----
// csic_sva: port checks for the card socket interrupt block
`timescale 1ns/10ps
module csic_sva #(
   parameter int NUM_SOCKETS = 2,
   parameter int IRQ_LINES   = 16
) (
   input logic                        clk_sys,
   input logic                        reset_n,
   input logic                        ce,
   input logic [6:0]                  reg_addr,
   input logic                        reg_wr,
   input logic                        reg_rd,
   input logic [7:0]                  reg_wdata,
   input logic [7:0]                  reg_rdata,
   input logic                        reg_rvalid,
   input logic [NUM_SOCKETS-1:0][3:0] status_change_src_enable,
   input logic [NUM_SOCKETS-1:0]      ring_indicate_enable,
   input logic [NUM_SOCKETS-1:0]      card_reset,
   input logic [NUM_SOCKETS-1:0]      socket_card_kind,
   input logic [IRQ_LINES-1:0]        irq_line
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);

   sequence s_wr(logic [6:0] a);
      ce && reg_wr && reg_addr == a;
   endsequence

   a_ring_follow: assert property (s_wr(7'h43) ##1 !reg_wr |->
      ##1 ring_indicate_enable[1] == $past(reg_wdata[7], 2)) else $error("ring enable wrong");
   a_reset_follow: assert property (s_wr(7'h43) ##1 !reg_wr |->
      ##1 card_reset[1] == !$past(reg_wdata[6], 2)) else $error("card reset wrong");
   a_kind_follow: assert property (s_wr(7'h03) ##1 !reg_wr |->
      ##1 socket_card_kind[0] == $past(reg_wdata[5], 2)) else $error("card kind wrong");
   a_reset_state: assert property ($rose(reset_n) |-> card_reset == 2'h3
      && ring_indicate_enable == 2'h0 && socket_card_kind == 2'h0) else $error("reset state");
   a_rvalid_once: assert property (ce |=> reg_rvalid == $past(reg_rd))
      else $error("rvalid timing");
   a_stat_upper: assert property (ce && reg_rd && reg_addr[5:0] == 6'h04
      |=> reg_rdata[7:4] == 4'h0) else $error("status upper bits");
   a_unmapped_zero: assert property (ce && reg_rd && !(reg_addr inside
      {7'h03, 7'h04, 7'h43, 7'h44}) |=> reg_rdata == 8'h00) else $error("unmapped read");
   a_masked_zero: assert property (ce && reg_rd && reg_addr == 7'h04
      && status_change_src_enable[0] == 4'h0 && $past(status_change_src_enable[0]) == 4'h0
      && $past(status_change_src_enable[0], 2) == 4'h0 |=> reg_rdata == 8'h00)
      else $error("disabled flag read");
   a_irq0_low: assert property (irq_line[0] == 1'b0) else $error("irq 0 driven");
endmodule

bind csic_top csic_sva #(.NUM_SOCKETS(NUM_SOCKETS), .IRQ_LINES(IRQ_LINES)) u_csic_sva (
   .clk_sys, .reset_n, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata, .reg_rvalid,
   .status_change_src_enable, .ring_indicate_enable, .card_reset, .socket_card_kind, .irq_line);

// ---- verification/csic_top_tb.sv ----
// csic_top_tb: self-checking bench for the card socket interrupt block
`timescale 1ns/10ps
module csic_top_tb;
   logic            clk_sys, reset_n, ce, reg_wr, reg_rd, reg_rvalid, smi_req;
   logic [6:0]      reg_addr, a;
   logic [7:0]      reg_wdata, reg_rdata, d;
   logic [1:0]      flag_clear_write_mode, card_ready, battery_detect1_ring_pin;
   logic [1:0]      battery_detect2, ring_indicate_enable, card_reset, socket_card_kind;
   logic [1:0]      pci_irq;
   logic [1:0][3:0] status_change_src_enable, status_change_irq_select;
   logic [1:0][1:0] card_detect_n;
   logic [15:0]     irq_line;
   int              bad_count, num_checks, s, ctl[2], fl[2];

   csic_card u_card (.card_detect_n, .card_ready, .battery_detect1_ring_pin, .battery_detect2);
   csic_top u_csic_top (.clk_sys, .reset_n, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
      .reg_rdata, .reg_rvalid, .flag_clear_write_mode, .status_change_src_enable,
      .status_change_irq_select, .card_detect_n, .card_ready, .battery_detect1_ring_pin,
      .battery_detect2, .ring_indicate_enable, .card_reset, .socket_card_kind, .pci_irq,
      .irq_line, .smi_req);

   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end

   task automatic end_sim;
      if (bad_count == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [6:0] ad, input logic [7:0] v);
      @(posedge clk_sys) #1;
      reg_addr = ad;
      reg_wdata = v;
      reg_wr = 1'b1;
      @(posedge clk_sys) #1;
      reg_wr = 1'b0;
      if (ad[5:0] == 6'h03) ctl[ad[6]] = v;
      if (ad[5:0] == 6'h04 && flag_clear_write_mode[ad[6]]) fl[ad[6]] &= ~int'(v);
   endtask

   task automatic rc(input logic [6:0] ad);
      logic [7:0] e;
      e = 8'h00;
      if (ad[5:0] == 6'h03) e = 8'(ctl[ad[6]]);
      if (ad[5:0] == 6'h04) e = 8'(fl[ad[6]]);
      @(posedge clk_sys) #1;
      reg_addr = ad;
      reg_rd = 1'b1;
      @(posedge clk_sys) #1;
      reg_rd = 1'b0;
      chk(16'(reg_rvalid), 16'h1);
      chk(16'(reg_rdata), 16'(e));
      if (ad[5:0] == 6'h04 && !flag_clear_write_mode[ad[6]]) fl[ad[6]] = 0;
   endtask

   // card pins move, then the model flags are updated and only pci_irq is compared
   task automatic ev(input logic [3:0] m, input logic [1:0] cd, input logic r, b1, b2);
      u_card.pins(s, cd, r, b1, b2);
      repeat (8) @(posedge clk_sys);
      fl[s] |= int'(m & status_change_src_enable[s] & (ctl[s][5] ? 4'h9 : 4'hF));
      #1;
      chk(16'(pci_irq[s]), 16'(fl[s] != 0 && (ctl[s][4] || ctl[s][3:0] == 0)));
   endtask

   initial begin
      #200000;
      bad_count++;
      end_sim();
   end

   initial begin
      {ce, reset_n, reg_wr, reg_rd, reg_addr, reg_wdata} = {1'b1, 18'h0};
      flag_clear_write_mode = '0;
      status_change_src_enable = '0;
      status_change_irq_select = '0;
      void'($urandom(15));
      repeat (4) @(posedge clk_sys);
      #1 reset_n = 1'b1;
      chk(16'(card_reset), 16'h3);
      ce = 1'b0;
      wr(7'h03, 8'h40);
      @(posedge clk_sys) #1;
      chk(16'(card_reset), 16'h3);
      ce = 1'b1;
      ctl[0] = 0;
      foreach (ctl[i]) begin
         rc(7'(i * 64 + 3));
         rc(7'(i * 64 + 4));
      end
      rc(7'h05);
      rc(7'h7F);
      repeat (8) begin
         s = $urandom % 2;
         d = 8'($urandom);
         wr(7'(s * 64 + 3), d);
         @(posedge clk_sys) #1;
         chk({ring_indicate_enable[s], card_reset[s], socket_card_kind[s]}, {d[7], ~d[6], d[5]});
         rc(7'(s * 64 + 3));
      end
      for (s = 0; s < 2; s++) begin
         a = 7'(s * 64);
         wr(a + 7'h03, 8'h40);
         status_change_src_enable[s] = 4'hF;
         ev(4'h8, 2'b01, 1'b1, 1'b1, 1'b1);
         wr(a + 7'h04, 8'h08);
         rc(a + 7'h04);
         rc(a + 7'h04);
         ev(4'h0, 2'b01, 1'b0, 1'b1, 1'b1);
         ev(4'h4, 2'b01, 1'b1, 1'b1, 1'b1);
         ev(4'h3, 2'b01, 1'b1, 1'b0, 1'b1);
         rc(a + 7'h04);
         flag_clear_write_mode[s] = 1'b1;
         ev(4'h8, 2'b00, 1'b1, 1'b1, 1'b1);
         rc(a + 7'h04);
         wr(a + 7'h04, 8'h08);
         rc(a + 7'h04);
         status_change_src_enable[s] = 4'h7;
         ev(4'h8, 2'b11, 1'b1, 1'b1, 1'b1);
         rc(a + 7'h04);
         flag_clear_write_mode[s] = 1'b0;
         status_change_src_enable[s] = 4'hF;
         wr(a + 7'h03, 8'hC0);
         ev(4'h0, 2'b11, 1'b1, 1'b1, 1'b0);
         ev(4'h1, 2'b11, 1'b1, 1'b0, 1'b0);
         ev(4'h0, 2'b11, 1'b1, 1'b1, 1'b1);
         rc(a + 7'h04);
      end
      s = 1;
      flag_clear_write_mode[1] = 1'b1;
      wr(7'h43, 8'h43);
      ev(4'h8, 2'b01, 1'b1, 1'b1, 1'b1);
      for (int c = 1; c < 16; c++) begin
         status_change_irq_select[1] = 4'(c);
         repeat (3) @(posedge clk_sys);
         #1;
         chk(irq_line, c == 2 ? 16'h0 : 16'h1 << c);
         chk(16'(smi_req), 16'(c == 2));
      end
      wr(7'h43, 8'h53);
      repeat (3) @(posedge clk_sys);
      #1;
      chk(16'(pci_irq[1]), 16'h1);
      chk(irq_line, 16'h0);
      wr(7'h44, 8'h08);
      status_change_irq_select[1] = 4'h0;
      u_card.pins(1, 2'b01, 1'b0, 1'b1, 1'b1);
      for (int c = 0; c < 16; c++) begin
         wr(7'h43, 8'h60 | 8'(c));
         repeat (3) @(posedge clk_sys);
         #1;
         chk(irq_line, (c == 0 || c == 2) ? 16'h0 : 16'h1 << c);
         chk(16'(smi_req), 16'(c == 2));
      end
      ev(4'h4, 2'b01, 1'b1, 1'b1, 1'b1);
      rc(7'h44);
      end_sim();
   end
endmodule
